// ### rtl/mca_pkg.sv
// constants and types for the two-wire master arbitration block
// assumes one 25 MHz core clock and a plain register port
package mca_pkg;

    // register indices on the plain port
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  OFS_FLAGS1 = 4'h0;
    localparam logic [3:0]  OFS_EN1    = 4'h1;
    localparam logic [3:0]  OFS_FLAGS2 = 4'h2;
    localparam logic [3:0]  OFS_EN2    = 4'h3;
    localparam logic [3:0]  OFS_BUF    = 4'h4;
    localparam logic [3:0]  OFS_RATE   = 4'h5;
    localparam logic [3:0]  OFS_CTRL1  = 4'h6;
    localparam logic [3:0]  OFS_CTRL2  = 4'h7;
    localparam logic [3:0]  OFS_STAT   = 4'h8;
    localparam logic [3:0]  OFS_CLR1   = 4'h9;
    localparam logic [3:0]  OFS_CLR2   = 4'hA;

    // field positions
    localparam int B_PORT_IF = 3;
    localparam int B_BCL_IF  = 3;
    localparam int C1_WCOL   = 7;
    localparam int C1_EN     = 5;
    localparam int C2_SEN    = 0;
    localparam int C2_RSEN   = 1;
    localparam int C2_PEN    = 2;
    localparam int C2_ACKEN  = 4;
    localparam int C2_ACKDT  = 5;
    localparam int C2_ACKST  = 6;
    localparam int ST_STOP   = 4;
    localparam int ST_START  = 3;
    localparam int ST_BF     = 0;

    // values
    localparam logic [3:0] MODE_MASTER = 4'h8;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [3:0] ACK_SLOT    = 4'h8;
    localparam logic [3:0] LAST_DATA   = 4'h7;

    typedef enum logic [3:0] {
        S_IDLE,
        S_ST_WAIT,
        S_ST_HOLD,
        S_RS_REL,
        S_RS_SCLW,
        S_RS_CNT,
        S_RS_HOLD,
        S_SP_LOW,
        S_SP_SCLW,
        S_SP_CNT,
        S_SP_CHK,
        S_BIT_LO,
        S_BIT_SCLW,
        S_BIT_HI
    } mca_state_t;

endpackage

// ### rtl/mca_arbiter.sv
// two-wire bus master with multi-master arbitration and collision checks
// assumes open-drain pads outside: oe high pulls the line low
//
// How it works
// R1: released data bit sampled low with clock high is a collision, port idles
// R2: collision in a byte stops it, clears buffer full, releases both lines
// R3: collision in a sequence aborts it and clears its control enable bit
// R4: after a collision, a bus stop condition sets the port interrupt flag
// R5: buffer write after a collision restarts from the first data bit
// R6: start and stop seen flags tell software when the bus may be claimed
// R7: start requested with data or clock low is a collision
// R8: start waits data high, counts reload bits; clock low then collides
// R9: data low during first start count drives data low early
// R10: second start count ignores clock low, then drives clock low
// R11: repeated start counts, releases clock, data low at clock high collides
// R12: data falling in the repeated start count is no collision
// R13: clock falling in repeated start count before data driven collides
// R14: repeated start drives data low, counts, then drives clock low
// R15: stop releases clock, counts after clock high, data low after collides
// R16: clock low during stop before data floats high collides
// R17: no collision for another master pulling data during a start
// R18: start and stop seen flags clear on reset and when disabled
// R19: collision checks only in master two-wire mode while enabled
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps

module mca_arbiter
    import mca_pkg::*;
#(
    parameter int BRG_W = 7
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // data line
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    // clock line
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe,
    // interrupt
    output logic                   irq
);

    mca_state_t       state_ff;
    logic [2:0]       sda_s_ff;
    logic [2:0]       scl_s_ff;
    logic             sda_f_ff;
    logic             scl_f_ff;
    logic             sda_q_ff;
    logic             start_seen_ff;
    logic             stop_seen_ff;
    logic             watch_ff;
    logic [BRG_W-1:0] cnt_ff;
    logic [7:0]       shreg_ff;
    logic [3:0]       bitcnt_ff;
    logic             sda_drv_ff;
    logic             scl_drv_ff;
    logic             is_ack_ff;
    logic             bf_ff;
    logic             ackst_ff;
    logic [5:0]       cmd_ff;
    logic             coll_ff;
    logic             done_ff;
    logic [7:0]       rate_ff;
    logic [7:0]       ctrl1_ff;
    logic [7:0]       en1_ff;
    logic [7:0]       en2_ff;
    logic             port_if_ff;
    logic             bcl_if_ff;
    logic [7:0]       rdata_ff;
    logic             master_on;
    logic             coll_now;
    logic             cnt_zero;
    logic             start_ev;
    logic             stop_ev;
    logic [BRG_W-1:0] load;
    logic             chk_bit;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    assign master_on = ctrl1_ff[C1_EN] && (ctrl1_ff[3:0] == MODE_MASTER);
    assign load      = rate_ff[BRG_W-1:0];
    assign cnt_zero  = (cnt_ff == '0);
    assign sda_out   = 1'b0;
    assign scl_out   = 1'b0;
    assign sda_oe    = sda_drv_ff;
    assign scl_oe    = scl_drv_ff;
    assign reg_rdata = rdata_ff;

    // three-stage synchronisers; level moves only once stages two and three agree
    always_ff @(posedge clock) begin
        if (rst) begin
            sda_s_ff <= 3'h7;
            scl_s_ff <= 3'h7;
            sda_f_ff <= 1'b1;
            scl_f_ff <= 1'b1;
        end else begin
            sda_s_ff <= {sda_s_ff[1:0], sda_in};
            scl_s_ff <= {scl_s_ff[1:0], scl_in};
            if (sda_s_ff[1] == sda_s_ff[2]) begin
                sda_f_ff <= sda_s_ff[2];
            end
            if (scl_s_ff[1] == scl_s_ff[2]) begin
                scl_f_ff <= scl_s_ff[2];
            end
        end
    end

    // bus condition monitor, runs even when another master owns the bus
    assign start_ev = scl_f_ff && sda_q_ff && !sda_f_ff;
    assign stop_ev  = scl_f_ff && !sda_q_ff && sda_f_ff;

    always_ff @(posedge clock) begin
        if (rst || !ctrl1_ff[C1_EN]) begin
            sda_q_ff      <= 1'b1;
            start_seen_ff <= 1'b0; // R18
            stop_seen_ff  <= 1'b0; // R18
        end else begin
            sda_q_ff <= sda_f_ff;
            if (start_ev) begin
                start_seen_ff <= 1'b1; // R6
                stop_seen_ff  <= 1'b0;
            end else if (stop_ev) begin
                stop_seen_ff  <= 1'b1; // R6
                start_seen_ff <= 1'b0;
            end
        end
    end

    // arm on collision, the next bus stop raises the port flag
    always_ff @(posedge clock) begin
        if (rst) begin
            watch_ff <= 1'b0;
        end else if (coll_ff) begin
            watch_ff <= 1'b1; // R4
        end else if (stop_ev) begin
            watch_ff <= 1'b0;
        end
    end

    // ack slot of a byte is the slave's, so a low there is no collision
    assign chk_bit = !sda_drv_ff && (is_ack_ff || bitcnt_ff != ACK_SLOT);

    always_comb begin
        coll_now = 1'b0;
        unique case (state_ff)
            S_IDLE:    coll_now = cmd_ff[C2_SEN] && (!sda_f_ff || !scl_f_ff); // R7
            S_ST_WAIT: coll_now = sda_f_ff && !scl_f_ff; // R8
            S_RS_SCLW: coll_now = scl_f_ff && !sda_f_ff; // R11
            S_RS_CNT:  coll_now = !scl_f_ff; // R13
            S_SP_CNT:  coll_now = !scl_f_ff; // R16
            S_SP_CHK:  coll_now = cnt_zero && !sda_f_ff; // R15
            S_BIT_HI:  coll_now = chk_bit && !sda_f_ff; // R1
            default:   coll_now = 1'b0;
        endcase
        coll_now = coll_now && master_on; // R19
    end

    // sequencer: bit rate counter, line drive, shift register
    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff   <= S_IDLE;
            cnt_ff     <= '0;
            shreg_ff   <= RST_BYTE;
            bitcnt_ff  <= '0;
            sda_drv_ff <= 1'b0;
            scl_drv_ff <= 1'b0;
            is_ack_ff  <= 1'b0;
            bf_ff      <= 1'b0;
            ackst_ff   <= 1'b0;
            cmd_ff     <= '0;
            coll_ff    <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            coll_ff <= 1'b0;
            done_ff <= 1'b0;
            if (!cnt_zero) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
            // sequence bits only accepted between operations
            if (reg_wr && hit(reg_addr, OFS_CTRL2) && state_ff == S_IDLE) begin
                cmd_ff <= reg_wdata[5:0];
            end
            if (!master_on) begin
                state_ff   <= S_IDLE;
                sda_drv_ff <= 1'b0;
                scl_drv_ff <= 1'b0;
            end else if (coll_now) begin
                state_ff          <= S_IDLE;
                sda_drv_ff        <= 1'b0; // R2
                scl_drv_ff        <= 1'b0; // R2
                bf_ff             <= 1'b0; // R2
                bitcnt_ff         <= '0;
                coll_ff           <= 1'b1;
                cmd_ff[C2_SEN]    <= 1'b0; // R3
                cmd_ff[C2_RSEN]   <= 1'b0; // R3
                cmd_ff[C2_PEN]    <= 1'b0; // R3
                cmd_ff[C2_ACKEN]  <= 1'b0; // R3
            end else begin
                unique case (state_ff)
                    S_IDLE: begin
                        if (cmd_ff[C2_SEN]) begin
                            cnt_ff   <= load;
                            state_ff <= S_ST_WAIT;
                        end else if (cmd_ff[C2_RSEN]) begin
                            sda_drv_ff <= 1'b0;
                            cnt_ff     <= load; // R11
                            state_ff   <= S_RS_REL;
                        end else if (cmd_ff[C2_PEN]) begin
                            sda_drv_ff <= 1'b1;
                            state_ff   <= S_SP_LOW;
                        end else if (cmd_ff[C2_ACKEN]) begin
                            is_ack_ff  <= 1'b1;
                            scl_drv_ff <= 1'b1;
                            sda_drv_ff <= !cmd_ff[C2_ACKDT];
                            cnt_ff     <= load;
                            state_ff   <= S_BIT_LO;
                        end else if (reg_wr && hit(reg_addr, OFS_BUF)) begin
                            shreg_ff   <= reg_wdata;
                            bitcnt_ff  <= '0; // R5
                            bf_ff      <= 1'b1;
                            is_ack_ff  <= 1'b0;
                            scl_drv_ff <= 1'b1;
                            sda_drv_ff <= !reg_wdata[7];
                            cnt_ff     <= load;
                            state_ff   <= S_BIT_LO;
                        end
                    end
                    S_ST_WAIT: begin
                        // another master pulling data early just shortens our start
                        if (!sda_f_ff || cnt_zero) begin
                            sda_drv_ff <= 1'b1; // R9 R17
                            cnt_ff     <= load; // R10
                            state_ff   <= S_ST_HOLD;
                        end
                    end
                    S_ST_HOLD: begin
                        if (cnt_zero) begin
                            scl_drv_ff     <= 1'b1; // R10
                            cmd_ff[C2_SEN] <= 1'b0;
                            done_ff        <= 1'b1;
                            state_ff       <= S_IDLE;
                        end
                    end
                    S_RS_REL: begin
                        if (cnt_zero) begin
                            scl_drv_ff <= 1'b0;
                            state_ff   <= S_RS_SCLW;
                        end
                    end
                    S_RS_SCLW: begin
                        if (scl_f_ff) begin
                            cnt_ff   <= load;
                            state_ff <= S_RS_CNT;
                        end
                    end
                    S_RS_CNT: begin
                        if (cnt_zero) begin
                            sda_drv_ff <= 1'b1; // R12 R14
                            cnt_ff     <= load;
                            state_ff   <= S_RS_HOLD;
                        end
                    end
                    S_RS_HOLD: begin
                        if (cnt_zero) begin
                            scl_drv_ff      <= 1'b1; // R14
                            cmd_ff[C2_RSEN] <= 1'b0;
                            done_ff         <= 1'b1;
                            state_ff        <= S_IDLE;
                        end
                    end
                    S_SP_LOW: begin
                        if (!sda_f_ff) begin
                            scl_drv_ff <= 1'b0; // R15
                            state_ff   <= S_SP_SCLW;
                        end
                    end
                    S_SP_SCLW: begin
                        if (scl_f_ff) begin
                            cnt_ff   <= load; // R15
                            state_ff <= S_SP_CNT;
                        end
                    end
                    S_SP_CNT: begin
                        if (cnt_zero) begin
                            sda_drv_ff <= 1'b0;
                            cnt_ff     <= load;
                            state_ff   <= S_SP_CHK;
                        end
                    end
                    S_SP_CHK: begin
                        if (cnt_zero) begin
                            cmd_ff[C2_PEN] <= 1'b0;
                            done_ff        <= 1'b1;
                            state_ff       <= S_IDLE;
                        end
                    end
                    S_BIT_LO: begin
                        if (cnt_zero) begin
                            scl_drv_ff <= 1'b0;
                            state_ff   <= S_BIT_SCLW;
                        end
                    end
                    S_BIT_SCLW: begin
                        // slaves may stretch the clock here
                        if (scl_f_ff) begin
                            cnt_ff   <= load;
                            state_ff <= S_BIT_HI;
                        end
                    end
                    S_BIT_HI: begin
                        if (cnt_zero) begin
                            scl_drv_ff <= 1'b1;
                            if (is_ack_ff) begin
                                sda_drv_ff       <= 1'b0;
                                cmd_ff[C2_ACKEN] <= 1'b0;
                                done_ff          <= 1'b1;
                                state_ff         <= S_IDLE;
                            end else if (bitcnt_ff == ACK_SLOT) begin
                                ackst_ff  <= sda_f_ff;
                                bf_ff     <= 1'b0;
                                bitcnt_ff <= '0;
                                done_ff   <= 1'b1;
                                state_ff  <= S_IDLE;
                            end else begin
                                bitcnt_ff  <= bitcnt_ff + 1'b1;
                                shreg_ff   <= {shreg_ff[6:0], 1'b0};
                                sda_drv_ff <= (bitcnt_ff == LAST_DATA) ? 1'b0 : !shreg_ff[6];
                                cnt_ff     <= load;
                                state_ff   <= S_BIT_LO;
                            end
                        end
                    end
                    default: begin
                        state_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // software registers; a write collision is a buffer write while busy
    always_ff @(posedge clock) begin
        if (rst) begin
            rate_ff  <= RST_BYTE;
            ctrl1_ff <= RST_BYTE;
            en1_ff   <= RST_BYTE;
            en2_ff   <= RST_BYTE;
        end else if (reg_wr) begin
            if (hit(reg_addr, OFS_RATE)) begin
                rate_ff <= reg_wdata;
            end
            if (hit(reg_addr, OFS_EN1)) begin
                en1_ff <= reg_wdata;
            end
            if (hit(reg_addr, OFS_EN2)) begin
                en2_ff <= reg_wdata;
            end
            if (hit(reg_addr, OFS_CTRL1)) begin
                ctrl1_ff <= reg_wdata;
            end else if (hit(reg_addr, OFS_BUF) && state_ff != S_IDLE) begin
                ctrl1_ff[C1_WCOL] <= 1'b1;
            end
        end
    end

    // sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge clock) begin
        if (rst) begin
            port_if_ff <= 1'b0;
            bcl_if_ff  <= 1'b0;
        end else begin
            port_if_ff <= (port_if_ff && !(reg_wr && hit(reg_addr, OFS_CLR1) && reg_wdata[B_PORT_IF]))
                          || done_ff || (watch_ff && stop_ev); // R4
            bcl_if_ff  <= (bcl_if_ff && !(reg_wr && hit(reg_addr, OFS_CLR2) && reg_wdata[B_BCL_IF]))
                          || coll_ff; // R1
        end
    end

    assign irq = (port_if_ff && en1_ff[B_PORT_IF]) || (bcl_if_ff && en2_ff[B_BCL_IF]);

    // read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_ff <= RST_BYTE;
        end else if (reg_rd) begin
            rdata_ff <= RST_BYTE;
            unique case (reg_addr)
                OFS_FLAGS1: rdata_ff[B_PORT_IF] <= port_if_ff;
                OFS_FLAGS2: rdata_ff[B_BCL_IF]  <= bcl_if_ff;
                OFS_EN1:    rdata_ff <= en1_ff;
                OFS_EN2:    rdata_ff <= en2_ff;
                OFS_BUF:    rdata_ff <= shreg_ff;
                OFS_RATE:   rdata_ff <= rate_ff;
                OFS_CTRL1:  rdata_ff <= ctrl1_ff;
                OFS_CTRL2:  rdata_ff <= {1'b0, ackst_ff, cmd_ff};
                OFS_STAT: begin
                    rdata_ff[ST_STOP]  <= stop_seen_ff;
                    rdata_ff[ST_START] <= start_seen_ff;
                    rdata_ff[ST_BF]    <= bf_ff;
                end
                default:    rdata_ff <= RST_BYTE;
            endcase
        end
    end

endmodule

// ### verification/mca_arbiter_checker.sv
// port assertions for the two-wire arbitration block
// assumes it is bound to mca_arbiter; enables are shadowed from register writes
`timescale 1ns/1ps
module mca_arbiter_checker
    import mca_pkg::*;
#(
    parameter int BRG_W = 7
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    // lines and interrupt
    input wire logic              scl_in,
    input wire logic              sda_oe,
    input wire logic              scl_oe,
    input wire logic              irq
);
    logic en1_ff;
    logic en2_ff;
    logic mst_ff;
    // shadow copies, so outputs can be tied to what software asked for
    always_ff @(posedge clock) begin
        if (rst) begin
            en1_ff <= 1'h0;
            en2_ff <= 1'h0;
            mst_ff <= 1'h0;
        end else if (reg_wr) begin
            if (reg_addr == OFS_EN1) en1_ff <= reg_wdata[B_PORT_IF];
            if (reg_addr == OFS_EN2) en2_ff <= reg_wdata[B_BCL_IF];
            if (reg_addr == OFS_CTRL1) mst_ff <= reg_wdata[C1_EN] && (reg_wdata[3:0] == MODE_MASTER);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_start_req; reg_wr && reg_addr == OFS_CTRL2 && reg_wdata[C2_SEN]; endsequence
    sequence s_scl_held; !scl_in [*4]; endsequence
    property p_rst_quiet; $fell(rst) |-> !sda_oe && !scl_oe && !irq; endproperty
    property p_off_quiet; !mst_ff [*3] |-> !sda_oe && !scl_oe; endproperty
    property p_start_refused; s_scl_held ##0 s_start_req |=> (!sda_oe && !scl_oe) [*8]; endproperty
    property p_start_order; $rose(sda_oe) && !scl_oe |=> (sda_oe && !scl_oe) [*3] ##[0:40] scl_oe; endproperty
    property p_irq_coll; reg_rd && reg_addr == OFS_FLAGS2 ##1 reg_rdata[B_BCL_IF] && en2_ff |-> irq; endproperty
    property p_irq_gate; !en1_ff && !en2_ff |-> !irq; endproperty
    property p_coll_free; $rose(irq) && !en1_ff |-> (!sda_oe && !scl_oe) [*4]; endproperty
    property p_stop_late; $fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> !$past(scl_oe, 3); endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("lines or irq active after reset");
    a_off_quiet: assert property (p_off_quiet) else $error("lines driven while not master");
    a_start_refused: assert property (p_start_refused) else $error("start on low clock line");
    a_start_order: assert property (p_start_order) else $error("start clock low out of order");
    a_irq_coll: assert property (p_irq_coll) else $error("collision flag enabled but no irq");
    a_irq_gate: assert property (p_irq_gate) else $error("irq with all enables clear");
    a_coll_free: assert property (p_coll_free) else $error("lines held after collision");
    a_stop_late: assert property (p_stop_late) else $error("data released too soon in stop");
endmodule

bind mca_arbiter mca_arbiter_checker #(.BRG_W(BRG_W)) mca_arbiter_checker_i (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scl_in, .sda_oe, .scl_oe, .irq
);

// ### verification/mca_bus_peer.sv
// other master on the shared open-drain lines, steered by the bench
// assumes pull-ups: a line that nobody pulls reads high
`timescale 1ns/1ps
module mca_bus_peer (
    // pacing
    input  wire logic clock,
    // device pull-downs
    input  wire logic sda_oe,
    input  wire logic scl_oe,
    // resolved lines
    output logic      sda_line,
    output logic      scl_line
);
    logic pull_sda = 1'h0;
    logic pull_scl = 1'h0;
    assign sda_line = !(sda_oe || pull_sda);
    assign scl_line = !(scl_oe || pull_scl);
    // half of a 320 ns link period
    task automatic half_bit();
        repeat (4) @(posedge clock);
    endtask
    // only sent once this master owns the bus, so it never cuts into a free bus
    task automatic send_stop();
        pull_scl <= 1'h1;
        half_bit();
        pull_sda <= 1'h1;
        half_bit();
        pull_scl <= 1'h0;
        half_bit();
        pull_sda <= 1'h0;
        half_bit();
    endtask
endmodule

// ### verification/tb_mca_arbiter.sv
// self-checking bench for the two-wire arbitration block
// assumes the bus peer model and the bound checker
`timescale 1ns/1ps
module tb_mca_arbiter import mca_pkg::*;;
    logic              clock = 1'h0;
    logic              rst = 1'h1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0]        reg_wdata = 8'h00;
    logic              reg_wr = 1'h0;
    logic              reg_rd = 1'h0;
    logic [7:0]        reg_rdata;
    logic              sda_line;
    logic              scl_line;
    logic              sda_out;
    logic              scl_out;
    logic              sda_oe;
    logic              scl_oe;
    logic              irq;
    logic [7:0]        q;
    logic [8:0]        bits;
    int                error_cnt = 0;
    int                n_compared = 0;

    always #20 clock = ~clock;

    mca_arbiter #(.BRG_W(7)) mca_arbiter_i (
        .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .sda_in (sda_line), .sda_out (sda_out), .sda_oe, .scl_in (scl_line), .scl_out (scl_out), .scl_oe, .irq
    );
    mca_bus_peer mca_bus_peer_i (.clock, .sda_oe, .scl_oe, .sda_line, .scl_line);

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
        #1;
    endtask
    // read a register; b < 0 compares the whole byte, else one bit
    task automatic rb(input logic [3:0] a, input int b, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1;
        q = reg_rdata;
        chk(b < 0 ? q : 8'(q[b]), e);
    endtask
    // bounded wait on an output: 0 data pull, 1 clock pull, 2 interrupt
    task automatic wt(input int s, input logic v);
        logic [2:0] sg;
        for (int n = 0; n < 4000; n++) begin
            sg = {irq, scl_oe, sda_oe};
            if (sg[s] === v) begin
                return;
            end
            @(posedge clock);
            #1;
        end
        error_cnt++;
        complete_run();
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'h0;
        rb(OFS_STAT, -1, 8'h00);
        rb(4'hF, -1, 8'h00);
        rb(OFS_CLR2, -1, 8'h00);
        wr(OFS_RATE, 8'h84);
        wr(OFS_CTRL1, 8'h28);
        wr(OFS_EN2, 8'h08);
        // own start, then a byte whose first released bit is overridden
        wr(OFS_CTRL2, 8'h01);
        wt(1, 1'h1);
        chk(8'(sda_oe), 8'h01);
        rb(OFS_STAT, ST_START, 8'h01);
        wr(OFS_CLR1, 8'h08);
        wr(OFS_BUF, 8'hFF);
        mca_bus_peer_i.pull_sda <= 1'h1;
        wt(2, 1'h1);
        chk(8'({sda_oe, scl_oe}), 8'h00);
        chk(8'({sda_out, scl_out}), 8'h00);
        rb(OFS_STAT, ST_BF, 8'h00);
        rb(OFS_FLAGS2, B_BCL_IF, 8'h01);
        rb(OFS_FLAGS1, B_PORT_IF, 8'h00);
        wr(OFS_CLR2, 8'h08);
        chk(8'(irq), 8'h00);
        mca_bus_peer_i.send_stop();
        rb(OFS_FLAGS1, B_PORT_IF, 8'h01);
        rb(OFS_STAT, ST_STOP, 8'h01);
        // new byte after the lost one goes out whole, msb first
        wr(OFS_CLR1, 8'h08);
        wr(OFS_BUF, 8'hA5);
        for (int i = 8; i >= 0; i--) begin
            wt(1, 1'h1);
            wt(1, 1'h0);
            bits[i] = !sda_oe;
        end
        wt(1, 1'h1);
        chk(bits[8:1], 8'hA5);
        // own stop
        wr(OFS_CTRL2, 8'h04);
        wt(0, 1'h1);
        wt(1, 1'h0);
        wt(0, 1'h0);
        repeat (12) @(posedge clock);
        rb(OFS_FLAGS2, B_BCL_IF, 8'h00);
        rb(OFS_CTRL2, C2_PEN, 8'h00);
        // rival pulls data during the first start count: early drive, no collision
        wr(OFS_RATE, 8'h20);
        wr(OFS_CTRL2, 8'h01);
        repeat (6) @(posedge clock);
        mca_bus_peer_i.pull_sda <= 1'h1;
        repeat (12) @(posedge clock);
        #1;
        chk(8'({sda_oe, scl_oe}), 8'h02);
        wt(1, 1'h1);
        rb(OFS_FLAGS2, B_BCL_IF, 8'h00);
        mca_bus_peer_i.pull_sda <= 1'h0;
        // repeated start meets data held low when its clock goes high
        wr(OFS_CTRL2, 8'h02);
        wt(0, 1'h0);
        repeat (8) @(posedge clock);
        mca_bus_peer_i.pull_sda <= 1'h1;
        wt(2, 1'h1);
        chk(8'({sda_oe, scl_oe}), 8'h00);
        rb(OFS_CTRL2, C2_RSEN, 8'h00);
        wr(OFS_CLR2, 8'h08);
        mca_bus_peer_i.pull_sda <= 1'h0;
        // start asked for while the clock line is held low; irq masked and cleared
        mca_bus_peer_i.pull_scl <= 1'h1;
        repeat (6) @(posedge clock);
        wr(OFS_CTRL2, 8'h01);
        wt(2, 1'h1);
        chk(8'(sda_oe), 8'h00);
        rb(OFS_CTRL2, C2_SEN, 8'h00);
        wr(OFS_EN2, 8'h00);
        chk(8'(irq), 8'h00);
        wr(OFS_EN2, 8'h08);
        chk(8'(irq), 8'h01);
        wr(OFS_CLR2, 8'h08);
        chk(8'(irq), 8'h00);
        mca_bus_peer_i.pull_scl <= 1'h0;
        // released ack bit meets a low line
        mca_bus_peer_i.pull_sda <= 1'h1;
        wr(OFS_CTRL2, 8'h30);
        wt(2, 1'h1);
        rb(OFS_CTRL2, C2_ACKEN, 8'h00);
        wr(OFS_CTRL1, 8'h00);
        rb(OFS_STAT, -1, 8'h00);
        complete_run();
    end
endmodule
